// *** src/flsb_bank.sv ***
// Fault-limit, fault-response and status register bank of a rectifier.
// Assumes a serial-bus framer on lnk_clk issues command-coded requests and
// that measurements and monitor flags arrive asynchronously to clk.
// Operation
// - Overvoltage warning threshold, default 56 V, alert when exceeded.
// - Undervoltage warning threshold, default 41 V, alert when below it.
// - Outside overload, output below 36 V shuts down unless input dropped.
// - Output undervoltage response only latched or restart, default restart.
// - Overcurrent limit programmable at high line, fixed 30 A at low line.
// - Overcurrent response latched or hiccup, default hiccup, both lines.
// - In overload, vout below low-voltage limit shuts down; input drop masks.
// - Overcurrent limit sets current limit; shutdown needs low-voltage fault.
// - Overcurrent warning programmable at high line, fixed 29 A at low line.
// - Overtemperature fault response is latched or hiccup, default hiccup.
// - Overtemperature warning when secondary sensor exceeds its threshold.
// - Input undervoltage warning, default 90 V, may only be raised.
// - Input undervoltage fault shuts down, default 85 V, may be raised.
// - Input undervoltage response latched or restart, default restart.
// - Written settings can be committed to non-volatile storage.
// - Summary byte: busy, off, vout OV, OC, vin UV, temp, comm, none.
// - Status word low byte is summary, high byte vout, iout, input summaries and off.
// - Output voltage status: OV fault, OV warn, UV warn, UV fault.
// - Current status: OC fault, overload low voltage, warn, share, limiting.
// - Input status: OV fault, OV warn, UV warn, UV fault, off for low input.
// - Temperature status: fault bit 7, warning bit 6, rest zero.
// - Clear-faults clears status and alert; live faults set again at once.
`timescale 1ns/100ps
`default_nettype none
`include "flsb_params.svh"

module flsb_bank #(
  parameter int unsigned HICCUP_CYCLES = `FLSB_HICCUP_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic lnk_clk,
  input wire logic lnk_srst,
  input wire logic lnk_req,
  input wire flsb_pkg::flsb_req_t lnk_cmd,
  output logic lnk_busy_r,
  output logic lnk_done_r,
  output logic [15:0] lnk_rdata_r,
  input wire flsb_pkg::flsb_meas_t meas,
  input wire flsb_pkg::flsb_flags_t flags,
  output logic alert_n_r,
  output logic output_off_r,
  output logic nvm_store_r
);
  import flsb_pkg::*;

  flsb_core_t r;
  flsb_core_t n;
  flsb_link_t lr;
  flsb_link_t ln;

  // Threshold register index: bit 4 marks a valid threshold command
  function automatic logic [4:0] thr_idx(input logic [7:0] c);
    case (c)
      `FLSB_CMD_VOUT_OVW: thr_idx = 5'h10;
      `FLSB_CMD_VOUT_UVW: thr_idx = 5'h11;
      `FLSB_CMD_VOUT_UVF: thr_idx = 5'h12;
      `FLSB_CMD_OC_F: thr_idx = 5'h13;
      `FLSB_CMD_OLV_F: thr_idx = 5'h14;
      `FLSB_CMD_OC_W: thr_idx = 5'h15;
      `FLSB_CMD_OT_F: thr_idx = 5'h16;
      `FLSB_CMD_OT_W: thr_idx = 5'h17;
      `FLSB_CMD_VIN_UVW: thr_idx = 5'h18;
      `FLSB_CMD_VIN_UVF: thr_idx = 5'h19;
      default: thr_idx = 5'h00;
    endcase
  endfunction : thr_idx

  // Link side: holds the request steady until the core acknowledges it,
  // so the core may read the held fields without a word crossing.
  always_comb begin
    ln = lr;
    ln.done = 1'b0;
    ln.ak1 = r.ack;
    ln.ak2 = lr.ak1;
    ln.ak3 = lr.ak2;
    if (lr.ak2 != lr.ak3) begin
      ln.busy = 1'b0;
      ln.done = 1'b1;
      ln.rdata = r.rdata;
    end else if (lnk_req && !lr.busy) begin
      ln.req = lnk_cmd;
      ln.tog = ~lr.tog;
      ln.busy = 1'b1;
    end
    if (lnk_srst) begin
      ln = '0;
    end
  end

  always_ff @(posedge lnk_clk) begin
    lr <= ln;
  end

  assign lnk_busy_r = lr.busy;
  assign lnk_done_r = lr.done;
  assign lnk_rdata_r = lr.rdata;

  // Core side
  logic overload;
  logic [15:0] oc_lim;
  logic [15:0] ocw_lim;
  logic vout_uvf;
  logic olv_f;
  logic ot_f;
  logic vin_uvf;
  logic clr;
  logic access;
  logic [3:0] fs;
  logic [3:0] lm;
  logic [3:0] hm;
  logic [4:0] ti;
  flsb_stat_t cond;
  logic [7:0] sum_byte;
  logic [7:0] word_hi;

  always_comb begin
    oc_lim = r.f2.high_line ? r.thr[3] : `FLSB_LOW_LINE_OC_F;
    ocw_lim = r.f2.high_line ? r.thr[5] : `FLSB_LOW_LINE_OC_W;
    overload = r.m2.iout >= oc_lim;
    vout_uvf = !overload && !r.f2.input_interrupt
      && (r.m2.vout < r.thr[2]);
    olv_f = overload && !r.f2.input_interrupt
      && (r.m2.vout < r.thr[4]);
    ot_f = r.m2.temp > r.thr[6];
    vin_uvf = r.m2.vin < r.thr[9];
    fs = {vin_uvf, ot_f, olv_f, vout_uvf};
    lm[0] = r.act[0] == `FLSB_ACT_LATCH;
    lm[1] = r.act[1] == `FLSB_ACT_OC_LATCH;
    lm[2] = r.act[2] == `FLSB_ACT_LATCH;
    lm[3] = r.act[3] == `FLSB_ACT_LATCH;
    hm = {1'b0, ~lm[2], ~lm[1], 1'b0};
    cond = '0;
    cond.vout[`FLSB_B_OVF] = r.f2.vout_ov_fault;
    cond.vout[`FLSB_B_OVW] = r.m2.vout > r.thr[0];
    cond.vout[`FLSB_B_UVW] = r.m2.vout < r.thr[1];
    cond.vout[`FLSB_B_UVF] = vout_uvf;
    cond.iout[`FLSB_B_OCF] = overload;
    cond.iout[`FLSB_B_OLV] = olv_f;
    cond.iout[`FLSB_B_OCW] = r.m2.iout > ocw_lim;
    cond.iout[`FLSB_B_SHARE] = r.f2.share_fault;
    cond.iout[`FLSB_B_PLIM] = r.f2.power_limit;
    cond.inp[`FLSB_B_OVF] = r.f2.vin_ov_fault;
    cond.inp[`FLSB_B_OVW] = r.f2.vin_ov_warn;
    cond.inp[`FLSB_B_UVW] = r.m2.vin < r.thr[8];
    cond.inp[`FLSB_B_UVF] = vin_uvf;
    cond.inp[`FLSB_B_LOWIN] = vin_uvf || r.lat[3];
    cond.temp[`FLSB_B_OVF] = ot_f;
    cond.temp[`FLSB_B_OVW] = r.m2.temp > r.thr[7];
    // Class summary bits are ORs of the sticky class bits; busy, off and comm follow live signals
    word_hi = {|r.st.vout, |r.st.iout, |r.st.inp, 1'b0,
      r.off, 1'b0, 1'b0, 1'b0};
    sum_byte[7] = r.f2.busy;
    sum_byte[6] = r.off;
    sum_byte[5] = r.st.vout[`FLSB_B_OVF];
    sum_byte[4] = r.st.iout[`FLSB_B_OCF];
    sum_byte[3] = r.st.inp[`FLSB_B_UVF];
    sum_byte[2] = |r.st.temp;
    sum_byte[1] = r.f2.comm_memory_fault;
    sum_byte[0] = (|word_hi) && !(|sum_byte[7:1]);
  end

  always_comb begin
    n = r;
    n.nvm_store = 1'b0;
    n.m1 = meas;
    n.m2 = r.m1;
    n.f1 = flags;
    n.f2 = r.f1;
    n.rs_d = r.f2.restart;
    n.rq1 = lr.tog;
    n.rq2 = r.rq1;
    n.rq3 = r.rq2;
    clr = 1'b0;
    access = r.rq2 != r.rq3;
    ti = thr_idx(lr.req.cmd);
    if (access) begin
      n.ack = ~r.ack;
      if (!lr.req.wr) begin
        case (lr.req.cmd)
          `FLSB_CMD_VOUT_UVA: n.rdata = {8'h00, r.act[0]};
          `FLSB_CMD_OC_A: n.rdata = {8'h00, r.act[1]};
          `FLSB_CMD_OT_A: n.rdata = {8'h00, r.act[2]};
          `FLSB_CMD_VIN_UVA: n.rdata = {8'h00, r.act[3]};
          `FLSB_CMD_ST_BYTE: n.rdata = {8'h00, sum_byte};
          `FLSB_CMD_ST_WORD: n.rdata = {word_hi, sum_byte};
          `FLSB_CMD_ST_VOUT: n.rdata = {8'h00, r.st.vout};
          `FLSB_CMD_ST_IOUT: n.rdata = {8'h00, r.st.iout};
          `FLSB_CMD_ST_INP: n.rdata = {8'h00, r.st.inp};
          `FLSB_CMD_ST_TEMP: n.rdata = {8'h00, r.st.temp};
          default: n.rdata = ti[4] ? r.thr[ti[3:0]] : 16'hffff;
        endcase
      end else begin
        case (lr.req.cmd)
          `FLSB_CMD_CLEAR: clr = 1'b1;
          `FLSB_CMD_STORE: n.nvm_store = 1'b1;
          `FLSB_CMD_VOUT_UVA: begin
            if (lr.req.wdata[7:0] == `FLSB_ACT_LATCH
                || lr.req.wdata[7:0] == `FLSB_ACT_RESTART) begin
              n.act[0] = lr.req.wdata[7:0];
            end
          end
          `FLSB_CMD_OC_A: begin
            if (lr.req.wdata[7:0] == `FLSB_ACT_OC_LATCH
                || lr.req.wdata[7:0] == `FLSB_ACT_OC_HICCUP) begin
              n.act[1] = lr.req.wdata[7:0];
            end
          end
          `FLSB_CMD_OT_A: begin
            if (lr.req.wdata[7:0] == `FLSB_ACT_LATCH
                || lr.req.wdata[7:0] == `FLSB_ACT_OT_HICCUP) begin
              n.act[2] = lr.req.wdata[7:0];
            end
          end
          `FLSB_CMD_VIN_UVA: begin
            if (lr.req.wdata[7:0] == `FLSB_ACT_LATCH
                || lr.req.wdata[7:0] == `FLSB_ACT_RESTART) begin
              n.act[3] = lr.req.wdata[7:0];
            end
          end
          default: begin
            // Input undervoltage limits only move upward
            if (ti[4] && (ti[3:0] < 4'd8
                || lr.req.wdata >= r.thr[ti[3:0]])) begin
              n.thr[ti[3:0]] = lr.req.wdata;
            end
          end
        endcase
      end
    end
    // A condition present in the clearing cycle wins over the clear
    for (int i = 0; i < 32; i++) begin
      n.st[i] = (r.st[i] && !clr) || cond[i];
    end
    // Latches release only on a restart pin edge, as a unit power cycle would
    for (int i = 0; i < 4; i++) begin
      n.lat[i] = (r.lat[i] && !(r.f2.restart && !r.rs_d))
        || (fs[i] && lm[i]);
    end
    if (|(fs & hm)) begin
      n.hic = HICCUP_CYCLES;
    end else if (r.hic != 32'h0) begin
      n.hic = r.hic - 32'h1;
    end
    n.off = (|(fs & ~lm & ~hm)) || (|r.lat) || (r.hic != 32'h0);
    n.alert_n = !(|n.st);
    if (srst) begin
      n = '0;
      n.alert_n = 1'b1;
      n.thr[0] = `FLSB_DEF_VOUT_OVW;
      n.thr[1] = `FLSB_DEF_VOUT_UVW;
      n.thr[2] = `FLSB_DEF_VOUT_UVF;
      n.thr[3] = `FLSB_DEF_OC_F;
      n.thr[4] = `FLSB_DEF_OLV_F;
      n.thr[5] = `FLSB_DEF_OC_W;
      n.thr[6] = `FLSB_DEF_OT_F;
      n.thr[7] = `FLSB_DEF_OT_W;
      n.thr[8] = `FLSB_DEF_VIN_UVW;
      n.thr[9] = `FLSB_DEF_VIN_UVF;
      n.act[0] = `FLSB_ACT_RESTART;
      n.act[1] = `FLSB_ACT_OC_HICCUP;
      n.act[2] = `FLSB_ACT_OT_HICCUP;
      n.act[3] = `FLSB_ACT_RESTART;
      // Synchronisers keep running, else zero codes look like faults after reset
      n.m1 = meas;
      n.m2 = r.m1;
      n.f1 = flags;
      n.f2 = r.f1;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign alert_n_r = r.alert_n;
  assign output_off_r = r.off;
  assign nvm_store_r = r.nvm_store;

  property p_ovw_alert;
    @(posedge clk) disable iff (srst)
    (r.m2.vout > r.thr[0]) |=> (r.st.vout[6] && !alert_n_r);
  endproperty
  a_ovw_alert: assert property (p_ovw_alert)
    else $error("ov warn no alert");

  property p_uvw_set;
    @(posedge clk) disable iff (srst)
    (r.m2.vout < r.thr[1]) |=> r.st.vout[5] ##1 (r.st.vout[5] || $past(clr));
  endproperty
  a_uvw_set: assert property (p_uvw_set)
    else $error("uv warn not held");

  property p_uvf_off;
    @(posedge clk) disable iff (srst)
    (vout_uvf && r.act[0] == 8'hc0) |=> output_off_r;
  endproperty
  a_uvf_off: assert property (p_uvf_off)
    else $error("uv fault no off");

  property p_bad_act;
    @(posedge clk) disable iff (srst)
    (access && lr.req.wr && lr.req.cmd == 8'h45
      && lr.req.wdata[7:0] != 8'h80 && lr.req.wdata[7:0] != 8'hc0)
      |=> $stable(r.act[0]);
  endproperty
  a_bad_act: assert property (p_bad_act)
    else $error("bad action taken");

  property p_low_line_oc;
    @(posedge clk) disable iff (srst)
    (!r.f2.high_line && r.m2.iout >= 16'h0780) |=> r.st.iout[7];
  endproperty
  a_low_line_oc: assert property (p_low_line_oc)
    else $error("low line oc");

  property p_latch_off;
    @(posedge clk) disable iff (srst)
    (|r.lat) |=> output_off_r;
  endproperty
  a_latch_off: assert property (p_latch_off)
    else $error("latch not off");

  property p_vin_raise;
    @(posedge clk) disable iff (srst)
    (access && lr.req.wr && lr.req.cmd == 8'h58
      && lr.req.wdata < r.thr[8]) |=> $stable(r.thr[8]);
  endproperty
  a_vin_raise: assert property (p_vin_raise)
    else $error("vin warn lowered");

  property p_store;
    @(posedge clk) disable iff (srst)
    (access && lr.req.wr && lr.req.cmd == 8'h15)
      |=> nvm_store_r ##1 !nvm_store_r;
  endproperty
  a_store: assert property (p_store)
    else $error("store pulse wrong");

  property p_otw;
    @(posedge clk) disable iff (srst)
    (r.m2.temp > r.thr[7]) |=> r.st.temp[6];
  endproperty
  a_otw: assert property (p_otw)
    else $error("ot warn missed");

  property p_clear_live;
    @(posedge clk) disable iff (srst)
    clr |=> (r.st == $past(cond)) && (alert_n_r == !(|$past(cond)));
  endproperty
  a_clear_live: assert property (p_clear_live)
    else $error("clear not live");

  property p_sticky;
    @(posedge clk) disable iff (srst)
    !clr |=> ((r.st & $past(r.st)) == $past(r.st));
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status bit lost");

  property p_low_line_ocw;
    @(posedge clk) disable iff (srst)
    (!r.f2.high_line && r.m2.iout > 16'h0740) |=> r.st.iout[5];
  endproperty
  a_low_line_ocw: assert property (p_low_line_ocw)
    else $error("low line oc warn");

  property p_vin_uvf_off;
    @(posedge clk) disable iff (srst)
    (vin_uvf && r.act[3] == 8'hc0) |=> output_off_r;
  endproperty
  a_vin_uvf_off: assert property (p_vin_uvf_off)
    else $error("vin uv no off");

endmodule : flsb_bank
`default_nettype wire

// *** src/flsb_params.svh ***
// Constants of the fault-limit and status bank: command codes, defaults,
// action encodings, status bit positions and timing.
// Assumes measurement codes share the scale of the threshold registers.
`ifndef FLSB_PARAMS_SVH
`define FLSB_PARAMS_SVH

`define FLSB_CMD_CLEAR 8'h03
`define FLSB_CMD_STORE 8'h15
`define FLSB_CMD_VOUT_OVW 8'h42
`define FLSB_CMD_VOUT_UVW 8'h43
`define FLSB_CMD_VOUT_UVF 8'h44
`define FLSB_CMD_VOUT_UVA 8'h45
`define FLSB_CMD_OC_F 8'h46
`define FLSB_CMD_OC_A 8'h47
`define FLSB_CMD_OLV_F 8'h48
`define FLSB_CMD_OC_W 8'h4a
`define FLSB_CMD_OT_F 8'h4f
`define FLSB_CMD_OT_A 8'h50
`define FLSB_CMD_OT_W 8'h51
`define FLSB_CMD_VIN_UVW 8'h58
`define FLSB_CMD_VIN_UVF 8'h59
`define FLSB_CMD_VIN_UVA 8'h5a
`define FLSB_CMD_ST_BYTE 8'h78
`define FLSB_CMD_ST_WORD 8'h79
`define FLSB_CMD_ST_VOUT 8'h7a
`define FLSB_CMD_ST_IOUT 8'h7b
`define FLSB_CMD_ST_INP 8'h7c
`define FLSB_CMD_ST_TEMP 8'h7d

// Threshold defaults: volts x512, amperes x64, input volts x64, deg C x64
`define FLSB_DEF_VOUT_OVW 16'h7000
`define FLSB_DEF_VOUT_UVW 16'h5200
`define FLSB_DEF_VOUT_UVF 16'h4800
`define FLSB_DEF_OC_F 16'h0f00
`define FLSB_DEF_OLV_F 16'h4800
`define FLSB_DEF_OC_W 16'h0ec0
`define FLSB_DEF_OT_F 16'h1b80
`define FLSB_DEF_OT_W 16'h1a40
`define FLSB_DEF_VIN_UVW 16'h1680
`define FLSB_DEF_VIN_UVF 16'h1540
`define FLSB_LOW_LINE_OC_F 16'h0780
`define FLSB_LOW_LINE_OC_W 16'h0740

`define FLSB_ACT_LATCH 8'h80
`define FLSB_ACT_RESTART 8'hc0
`define FLSB_ACT_OC_LATCH 8'hc0
`define FLSB_ACT_OC_HICCUP 8'hf8
`define FLSB_ACT_OT_HICCUP 8'hc0

`define FLSB_B_OVF 7
`define FLSB_B_OVW 6
`define FLSB_B_UVW 5
`define FLSB_B_UVF 4
`define FLSB_B_OCF 7
`define FLSB_B_OLV 6
`define FLSB_B_OCW 5
`define FLSB_B_SHARE 3
`define FLSB_B_PLIM 2
`define FLSB_B_LOWIN 3

`define FLSB_CLK_HZ 20000000
`define FLSB_HICCUP_MS 1000
`define FLSB_HICCUP_CYC (`FLSB_HICCUP_MS * (`FLSB_CLK_HZ / 1000))

`endif

// *** src/flsb_pkg.sv ***
// Types of the fault-limit and status bank.
// Assumes flsb_params.svh supplies all numeric constants.
`default_nettype none
package flsb_pkg;

  typedef struct packed {
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] vin;
    logic [15:0] temp;
  } flsb_meas_t;

  typedef struct packed {
    logic high_line;
    logic input_interrupt;
    logic vout_ov_fault;
    logic share_fault;
    logic power_limit;
    logic vin_ov_fault;
    logic vin_ov_warn;
    logic comm_memory_fault;
    logic busy;
    logic restart;
  } flsb_flags_t;

  typedef struct packed {
    logic wr;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } flsb_req_t;

  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] inp;
    logic [7:0] temp;
  } flsb_stat_t;

  typedef struct packed {
    flsb_meas_t m1;
    flsb_meas_t m2;
    flsb_flags_t f1;
    flsb_flags_t f2;
    logic rs_d;
    logic rq1;
    logic rq2;
    logic rq3;
    logic ack;
    logic [15:0] rdata;
    logic [9:0][15:0] thr;
    logic [3:0][7:0] act;
    flsb_stat_t st;
    logic [3:0] lat;
    logic [31:0] hic;
    logic off;
    logic alert_n;
    logic nvm_store;
  } flsb_core_t;

  typedef struct packed {
    flsb_req_t req;
    logic tog;
    logic busy;
    logic done;
    logic [15:0] rdata;
    logic ak1;
    logic ak2;
    logic ak3;
  } flsb_link_t;

endpackage : flsb_pkg
`default_nettype wire

// *** tb/flsb_host.sv ***
// Host controller model driving the request side of the bank's link.
// Assumes one request at a time; the bench calls xfer by hierarchical name.
`timescale 1ns/100ps
`default_nettype none

module flsb_host (
  input wire logic lnk_clk,
  output var flsb_pkg::flsb_req_t lnk_cmd,
  output var logic lnk_req,
  input wire logic lnk_busy_r,
  input wire logic lnk_done_r,
  input wire logic [15:0] lnk_rdata_r
);
  import flsb_pkg::*;

  initial begin
    lnk_req = 1'b0;
    lnk_cmd = '0;
  end

  task automatic xfer(input logic wr, input logic [7:0] cmd,
      input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    int n;
    n = 0;
    @(negedge lnk_clk);
    while (lnk_busy_r !== 1'b0 && n < 60) begin
      @(negedge lnk_clk);
      n++;
    end
    lnk_cmd <= '{wr: wr, cmd: cmd, wdata: wd};
    lnk_req <= 1'b1;
    @(negedge lnk_clk);
    // Taken at the edge just passed; scramble fields so stale data is unusable
    lnk_req <= 1'b0;
    lnk_cmd <= flsb_req_t'(~lnk_cmd);
    n = 0;
    while (lnk_done_r !== 1'b1 && n < 60) begin
      @(negedge lnk_clk);
      n++;
    end
    ok = (lnk_done_r === 1'b1);
    rd = lnk_rdata_r;
  endtask : xfer

endmodule : flsb_host
`default_nettype wire

// *** tb/flsb_bank_tb.sv ***
// Self-checking bench of the fault-limit and status bank.
// Assumes the host model in flsb_host.sv and a shortened hiccup time.
`timescale 1ns/100ps
`default_nettype none
`include "flsb_params.svh"

module flsb_bank_tb;
  import flsb_pkg::*;
  logic clk, srst, lnk_clk, lnk_srst, lnk_req;
  flsb_req_t lnk_cmd;
  logic lnk_busy_r, lnk_done_r, alert_n_r, output_off_r, nvm_store_r;
  logic [15:0] lnk_rdata_r, rd;
  flsb_meas_t meas;
  flsb_flags_t flags;
  int err_total, checks, cyc, nstore;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Link clock offset so its edges never line up with the core clock
  initial begin
    lnk_clk = 1'b0;
    #3.7;
    forever #6 lnk_clk = ~lnk_clk;
  end

  flsb_bank #(.HICCUP_CYCLES(20)) dut (.clk(clk), .srst(srst),
    .lnk_clk(lnk_clk), .lnk_srst(lnk_srst), .lnk_req(lnk_req),
    .lnk_cmd(lnk_cmd), .lnk_busy_r(lnk_busy_r), .lnk_done_r(lnk_done_r),
    .lnk_rdata_r(lnk_rdata_r), .meas(meas), .flags(flags),
    .alert_n_r(alert_n_r), .output_off_r(output_off_r),
    .nvm_store_r(nvm_store_r));
  flsb_host host (.lnk_clk(lnk_clk), .lnk_cmd(lnk_cmd), .lnk_req(lnk_req),
    .lnk_busy_r(lnk_busy_r), .lnk_done_r(lnk_done_r),
    .lnk_rdata_r(lnk_rdata_r));

  always @(posedge clk) begin
    if (nvm_store_r === 1'b1) begin
      nstore <= nstore + 1;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask : cb
  task automatic acc(input logic wr, input logic [7:0] c,
      input logic [15:0] d);
    logic ok;
    host.xfer(wr, c, d, rd, ok);
    cb("link done", 1'b1, ok);
  endtask : acc
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    acc(1'b0, c, 16'h0000);
    chk($sformatf("reg %h", c), e, rd);
  endtask : rdc
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic clr;
    acc(1'b1, 8'h03, 16'h0000);
    wt(6);
  endtask : clr

  task automatic t_defaults;
    rdc(8'h42, `FLSB_DEF_VOUT_OVW);
    rdc(8'h43, `FLSB_DEF_VOUT_UVW);
    rdc(8'h44, `FLSB_DEF_VOUT_UVF);
    rdc(8'h45, 16'h00c0);
    rdc(8'h47, 16'h00f8);
    rdc(8'h48, `FLSB_DEF_OLV_F);
    rdc(8'h50, 16'h00c0);
    rdc(8'h58, `FLSB_DEF_VIN_UVW);
    rdc(8'h59, `FLSB_DEF_VIN_UVF);
    rdc(8'h5a, 16'h00c0);
    for (int a = 8'h78; a <= 8'h7d; a++) begin
      rdc(8'(a), 16'h0000);
    end
    rdc(8'h77, 16'hffff);
    cb("alert_n", 1'b1, alert_n_r);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_warn;
    meas.vout = 16'h7001;
    wt(6);
    cb("alert_n", 1'b0, alert_n_r);
    rdc(8'h7a, 16'h0040);
    rdc(8'h78, 16'h0001);
    rdc(8'h79, 16'h8001);
    clr;
    rdc(8'h7a, 16'h0040);
    meas.vout = 16'h5100;
    wt(6);
    rdc(8'h7a, 16'h0060);
    meas.vout = 16'h6800;
    clr;
    rdc(8'h7a, 16'h0000);
    cb("alert_n", 1'b1, alert_n_r);
    $display("test warnings done");
  endtask : t_warn

  task automatic t_resp;
    acc(1'b1, 8'h45, 16'h0012);
    rdc(8'h45, 16'h00c0);
    acc(1'b1, 8'h58, 16'h1600);
    rdc(8'h58, 16'h1680);
    acc(1'b1, 8'h58, 16'h1700);
    rdc(8'h58, 16'h1700);
    acc(1'b1, 8'h59, 16'h1500);
    rdc(8'h59, 16'h1540);
    flags.input_interrupt = 1'b1;
    meas.vout = 16'h4700;
    wt(6);
    cb("off masked", 1'b0, output_off_r);
    flags.input_interrupt = 1'b0;
    wt(6);
    cb("off uv", 1'b1, output_off_r);
    rdc(8'h7a, 16'h0030);
    meas.vout = 16'h6800;
    wt(6);
    cb("off restart", 1'b0, output_off_r);
    acc(1'b1, 8'h45, 16'h0080);
    rdc(8'h45, 16'h0080);
    meas.vout = 16'h4700;
    wt(6);
    meas.vout = 16'h6800;
    wt(6);
    cb("off latched", 1'b1, output_off_r);
    // Latch kept the unit off, then a restart pin pulse releases it
    flags.restart = 1'b1;
    wt(6);
    flags.restart = 1'b0;
    cb("off released", 1'b0, output_off_r);
    clr;
    $display("test responses done");
  endtask : t_resp

  task automatic t_hiccup;
    meas.temp = 16'h1b81;
    wt(6);
    cb("off ot", 1'b1, output_off_r);
    rdc(8'h7d, 16'h00c0);
    rdc(8'h78, 16'h0044);
    meas.temp = 16'h0a00;
    wt(12);
    cb("off hiccup", 1'b1, output_off_r);
    wt(30);
    cb("off end", 1'b0, output_off_r);
    clr;
    $display("test hiccup done");
  endtask : t_hiccup

  task automatic t_oc;
    meas.iout = 16'h0780;
    wt(6);
    rdc(8'h7b, 16'h0000);
    flags.high_line = 1'b0;
    meas.iout = 16'h0750;
    wt(6);
    rdc(8'h7b, 16'h0020);
    meas.iout = 16'h0780;
    wt(6);
    rdc(8'h7b, 16'h00a0);
    cb("off overload", 1'b0, output_off_r);
    meas.vout = 16'h4700;
    wt(6);
    cb("off olv", 1'b1, output_off_r);
    rdc(8'h7b, 16'h00e0);
    meas.vout = 16'h6800;
    meas.iout = 16'h0100;
    wt(42);
    cb("off oc hiccup", 1'b0, output_off_r);
    flags.high_line = 1'b1;
    clr;
    $display("test overcurrent done");
  endtask : t_oc

  task automatic t_status;
    meas.vin = 16'h1500;
    wt(6);
    cb("off vin", 1'b1, output_off_r);
    rdc(8'h7c, 16'h0038);
    rdc(8'h79, 16'h2848);
    meas.vin = 16'h3980;
    wt(6);
    cb("off vin restart", 1'b0, output_off_r);
    clr;
    flags.vout_ov_fault = 1'b1;
    flags.share_fault = 1'b1;
    flags.power_limit = 1'b1;
    flags.vin_ov_fault = 1'b1;
    flags.vin_ov_warn = 1'b1;
    flags.busy = 1'b1;
    flags.comm_memory_fault = 1'b1;
    wt(6);
    rdc(8'h7a, 16'h0080);
    rdc(8'h7b, 16'h000c);
    rdc(8'h7c, 16'h00c0);
    rdc(8'h79, 16'he0a2);
    flags = '0;
    flags.high_line = 1'b1;
    clr;
    rdc(8'h78, 16'h0000);
    $display("test status flags done");
  endtask : t_status

  task automatic t_store;
    int n0;
    n0 = nstore;
    acc(1'b1, 8'h15, 16'h0000);
    wt(6);
    chk("store pulses", 16'h0001, 16'(nstore - n0));
    $display("test store done");
  endtask : t_store

  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  always @(negedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results;
    end
  end

  initial begin
    srst = 1'b1;
    lnk_srst = 1'b1;
    meas = '{vout: 16'h6800, iout: 16'h0100, vin: 16'h3980, temp: 16'h0a00};
    flags = '0;
    flags.high_line = 1'b1;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    @(negedge lnk_clk);
    lnk_srst = 1'b0;
    wt(4);
    t_defaults;
    t_warn;
    t_resp;
    t_hiccup;
    t_oc;
    t_status;
    t_store;
    results;
  end

endmodule : flsb_bank_tb
`default_nettype wire
